//--- dv/flash_array_model.sv
// Behavioural flash array facing the erase controller
`timescale 1ns/10ps
module flash_array_model #(
  parameter integer PAGE_WORDS = 64  // Words in one page
) (
  input wire logic        clk_i,         // Clock
  input wire logic        erase_page_i,  // Page erase level
  input wire logic        erase_all_i,   // Erase all level
  input wire logic        write_i,       // Word write level
  input wire logic [31:0] addr_i,        // Target
  input wire logic [31:0] wdata_i        // Word data
);
  logic [31:0] mem [0:255];     // Small window of the array
  logic [2:0]  prev = 3'h0;     // Strobes of last cycle
  integer      j;               // Loop index
  initial for (j = 0; j < 256; j++) mem[j] = 32'hFFFFFFFF;
  // Each operation acts once, as its strobe rises
  always @(posedge clk_i) begin
    prev <= {write_i, erase_all_i, erase_page_i};
    if (write_i && !prev[2]) mem[addr_i[9:2]] <= mem[addr_i[9:2]] & wdata_i;
    if (erase_page_i && !prev[0])
      for (j = 0; j < PAGE_WORDS; j++) mem[(addr_i[9:2] & ~(PAGE_WORDS - 1)) + j] <= 32'hFFFFFFFF;
    if (erase_all_i && !prev[1])
      for (j = 0; j < 256; j++) mem[j] <= 32'hFFFFFFFF;
  end
endmodule  // flash_array_model

//--- dv/nvm_erase_controller_monitor.sv
// Port-level assertion checker of the erase controller
`timescale 1ns/10ps
`include "nvm_erase_defs.vh"
module nvm_erase_controller_monitor #(
  parameter integer MS_CYC = 25000  // Cycles per ms
) (
  input wire logic        clk_i,               // Clock
  input wire logic        reset_n_i,           // Reset, active low
  input wire logic [11:0] addr_i,              // Address
  input wire logic [31:0] wdata_i,             // Write data
  input wire logic        wr_i,                // Write strobe
  input wire logic        rd_i,                // Read strobe
  input wire logic [31:0] rdata_o,             // Read data
  input wire logic        flash_erase_page_o,  // Page erase
  input wire logic        flash_erase_all_o,   // Erase all
  input wire logic        flash_erase_ucfg_o,  // Config erase
  input wire logic        flash_write_o,       // Word write
  input wire logic [31:0] flash_addr_o,        // Target
  input wire logic [31:0] flash_wdata_o,       // Word data
  input wire logic        ready_o              // Idle flag
);
  logic [1:0]  mode;  // Mirror of access mode
  logic [6:0]  cfg;   // Mirror of partial duration
  logic [31:0] lim;   // Longest page strobe allowed
  logic [31:0] cnt;   // Cycles the strobe has stood
  wire busy = flash_erase_page_o | flash_erase_all_o | flash_erase_ucfg_o | flash_write_o;
  wire take = wr_i & ready_o & ~busy;        // Write the controller acts on
  wire ers  = take & (mode == `MODE_ERASE);  // Accepted erase request
  // Mirrors follow accepted writes; counter times each strobe
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode <= `MODE_READ;
      cfg  <= `PART_CFG_RESET;
      lim  <= 32'h0;
      cnt  <= 32'h0;
    end else begin
      cnt <= busy ? cnt + 32'h1 : 32'h0;
      if (take && addr_i == `OFS_CONFIG) mode <= wdata_i[1:0];
      if (take && addr_i == `OFS_PART_CFG) cfg <= wdata_i[6:0];
      if (ers) lim <= (addr_i == `OFS_PART_ADDR) ? cfg * MS_CYC * 105 / 100 + 2
                                                 : `T_PAGE_MS * MS_CYC + 2;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_page_go; ers && (addr_i == `OFS_PAGE_ERASE || addr_i == `OFS_PAGE_ALIAS_B ||
    addr_i == `OFS_PART_ADDR) |=> flash_erase_page_o && flash_addr_o == $past(wdata_i); endproperty
  a_page_go: assert property (p_page_go) else $error("page start");
  property p_all_go; ers && addr_i == `OFS_FULL_ERASE && wdata_i[0] |=> flash_erase_all_o; endproperty
  a_all_go: assert property (p_all_go) else $error("all start");
  property p_ucfg_go; ers && addr_i == `OFS_UCFG_ERASE && wdata_i[0] |=> flash_erase_ucfg_o; endproperty
  a_ucfg_go: assert property (p_ucfg_go) else $error("config start");
  property p_refuse; take && mode != `MODE_ERASE |=> !(flash_erase_page_o || flash_erase_all_o ||
    flash_erase_ucfg_o); endproperty
  a_refuse: assert property (p_refuse) else $error("erase outside mode");
  property p_cfg_rd; rd_i && addr_i == `OFS_PART_CFG |=> rdata_o == {25'h0, $past(cfg)}; endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("partial config");
  property p_page_len; flash_erase_page_o |-> cnt <= lim; endproperty
  a_page_len: assert property (p_page_len) else $error("page too long");
  property p_all_len; flash_erase_all_o |-> cnt <= `T_ALL_MS * MS_CYC + 2; endproperty
  a_all_len: assert property (p_all_len) else $error("all too long");
  property p_wr_len; flash_write_o |-> cnt <= 32'd1027; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write too long");
  property p_busy; busy |=> !ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
endmodule  // nvm_erase_controller_monitor

//--- dv/nvm_erase_controller_test.sv
// Self-checking bench of the erase controller
`timescale 1ns/10ps
`include "nvm_erase_defs.vh"
module nvm_erase_controller_test;
  localparam integer MS = 10;  // Shortened cycles per ms
  logic        clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;  // Clock, reset, strobes
  logic [11:0] addr_i = 12'h000;                                // Address
  logic [31:0] wdata_i = 32'h0, rdata_o, flash_addr_o, flash_wdata_o, v, d1, d2, dur;  // Data
  logic        flash_erase_page_o, flash_erase_all_o, flash_erase_ucfg_o, flash_write_o, ready_o;
  integer      fail_count = 0, checks_done = 0, seed = 63, n, m, k;  // Counters
  logic [11:0] ofs [0:4] = '{`OFS_PAGE_ERASE, `OFS_PAGE_ALIAS_B, `OFS_FULL_ERASE,
                             `OFS_UCFG_ERASE, `OFS_PART_ADDR};  // Erase offsets
  nvm_erase_controller #(.MS_CYC(MS)) nvm_erase_controller_i (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .flash_erase_page_o(flash_erase_page_o), .flash_erase_all_o(flash_erase_all_o),
    .flash_erase_ucfg_o(flash_erase_ucfg_o), .flash_write_o(flash_write_o),
    .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .ready_o(ready_o));
  flash_array_model flash_array_model_i (.clk_i(clk_i), .erase_page_i(flash_erase_page_o),
    .erase_all_i(flash_erase_all_o), .write_i(flash_write_o), .addr_i(flash_addr_o),
    .wdata_i(flash_wdata_o));
  initial forever #20 clk_i = ~clk_i;
  // Strobes {write, config, all, page} an erase offset raises
  function automatic logic [3:0] stb(input integer i);
    stb = (i == 2) ? 4'h2 : (i == 3) ? 4'h4 : 4'h1;
  endfunction
  // Cycles an erase offset keeps the array busy
  function automatic integer len(input integer i);
    len = (i == 2) ? `T_ALL_MS * MS : (i == 4) ? dur * MS * 105 / 100 : `T_PAGE_MS * MS;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] x);
    @(posedge clk_i);
    addr_i <= o;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] o, input logic [31:0] e, input string s);
    @(posedge clk_i);
    addr_i <= o;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(s, e, rdata_o);
  endtask
  // Start a request, check strobes and busy flag, then time it
  task automatic run(input logic [11:0] o, input logic [31:0] x, input logic [3:0] s, input integer c);
    wr(o, x);
    #1;
    chk("strobes", {28'h0, s}, {28'h0, flash_write_o, flash_erase_ucfg_o, flash_erase_all_o,
        flash_erase_page_o});
    if (s[0]) chk("target", x, flash_addr_o);
    rd(`OFS_READY, {31'h0, s == 4'h0}, "ready");
    n = 0;
    while (ready_o !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      #1;
      n = n + 1;
    end
    chk("length", c, (n < c - 4 || n > c + 4) ? n : c);
    if (n == 5000) results();
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("ready", 32'h1, {31'h0, ready_o});
    rd(`OFS_PART_CFG, 32'h0000000A, "part cfg");
    for (m = 0; m < 3; m++) begin
      wr(`OFS_CONFIG, m);
      for (k = 0; k < 5; k++) begin
        dur = {$random(seed)} % 127 + 1;
        if (k == 4) wr(`OFS_PART_CFG, dur);
        if (k == 4) rd(`OFS_PART_CFG, dur, "part cfg");
        v = (k == 2 || k == 3) ? 32'h1 : {$random(seed)} & 32'h0003F000;
        run(ofs[k], v, (m == 2) ? stb(k) : 4'h0, (m == 2) ? len(k) : 0);
      end
      $display("mode %0d test done", m);
    end
    wr(`OFS_CONFIG, `MODE_WRITE);
    v = {$random(seed)} & 32'h000000FC;
    d1 = $random(seed);
    d2 = $random(seed);
    wr(`OFS_WORD_ADDR, v);
    run(`OFS_WORD_DATA, d1, 4'h8, 1025);
    wr(`OFS_WORD_ADDR, v);
    run(`OFS_WORD_DATA, d2, 4'h8, 1025);
    chk("word", d1 & d2, flash_array_model_i.mem[v[9:2]]);
    wr(`OFS_CONFIG, `MODE_ERASE);
    run(`OFS_PAGE_ALIAS_B, 32'h0, 4'h1, len(0));
    chk("erased", 32'hFFFFFFFF, flash_array_model_i.mem[v[9:2]]);
    $display("word test done");
    results();
  end
endmodule  // nvm_erase_controller_test
bind nvm_erase_controller nvm_erase_controller_monitor #(.MS_CYC(MS_CYC)) mon_i (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .flash_erase_page_o(flash_erase_page_o), .flash_erase_all_o(flash_erase_all_o),
  .flash_erase_ucfg_o(flash_erase_ucfg_o), .flash_write_o(flash_write_o),
  .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .ready_o(ready_o));

//--- verilog/nvm_erase_controller.v
// Erase and word-write sequencer of the on-chip non-volatile memory controller
// Contract
// - Page erase register write erases that page
// - Both alias registers act as page erase
// - Full erase trigger erases all user memory
// - Config area trigger erases user config area
// - Partial address write runs one partial step
// - Partial config: 7-bit ms duration, reset 10
// - Partial step at most duration times 1.05
// - Word write done in 41 us, busy meanwhile
// - Page erase completes within 85 ms
// - Erase all completes within 169 ms
// - Ready reads 0 busy, 1 idle
// - Mode 0 read, 1 write, 2 erase
// - Word write only clears bits to zero
// - Accumulated partial time reaching page time erases
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "nvm_erase_defs.vh"
module nvm_erase_controller #(
  parameter integer CLK_HZ  = `CLK_HZ,    // System clock rate
  parameter integer T_PAGE_MS = `T_PAGE_MS, // Page erase time in ms
  parameter integer T_ALL_MS  = `T_ALL_MS,  // Erase-all time in ms
  parameter integer MS_CYC  = CLK_HZ / 1000 // Cycles per ms, shortenable
) (
  input  wire        clk_i,        // System clock, 25 MHz
  input  wire        reset_n_i,    // Async reset, active low
  input  wire [11:0] addr_i,       // Register byte address
  input  wire [31:0] wdata_i,      // Register write data
  input  wire        wr_i,         // Write strobe
  input  wire        rd_i,         // Read strobe
  output reg  [31:0] rdata_o,      // Read data, cycle after strobe
  output reg         flash_erase_page_o, // Page erase pulse held during op
  output reg         flash_erase_all_o,  // Whole-array erase held during op
  output reg         flash_erase_ucfg_o, // Config area erase held during op
  output reg         flash_write_o,      // Word program held during op
  output reg  [31:0] flash_addr_o,       // Target address
  output reg  [31:0] flash_wdata_o,      // Word to program
  output reg         ready_o             // Controller idle
);
  // Cycle counts derived from the documented times
  localparam integer WRITE_CYC = (`T_WRITE_US * (CLK_HZ / 1000000)); // Rounded down
  localparam integer PAGE_CYC  = T_PAGE_MS * MS_CYC;   // Longest allowed
  localparam integer ALL_CYC   = T_ALL_MS * MS_CYC;    // Longest allowed

  reg  [1:0]  mode;            // Access mode field
  reg  [6:0]  part_ms;         // Partial step duration
  reg  [31:0] page_addr;       // Last page erase address
  reg  [31:0] part_addr;       // Last partial erase address
  reg  [31:0] word_addr;       // Word write address
  reg  [31:0] acc_cyc;         // Accumulated partial erase time
  reg  [31:0] acc_page;        // Page that the accumulation belongs to
  reg  [2:0]  op;              // Running operation
  reg  [15:0] erased_cnt;      // Completed erase cycles of partial pages
  reg         load;            // Timer load pulse
  reg  [31:0] load_cnt;        // Timer count
  wire        done;            // Timer expiry
  wire        busy;            // Operation active
  wire        erase_ok;        // Erase triggers armed
  wire [31:0] part_cyc;        // One partial step in cycles

  assign busy     = (op != `OP_IDLE);
  assign erase_ok = (mode == `MODE_ERASE) && !busy;
  // Step is duration times 1.05, the upper bound of the tolerance, not the nominal
  assign part_cyc = (({25'h0, part_ms} * MS_CYC[31:0]) * `ACC_NUM) / `ACC_DEN;

  nvm_tick_timer #(
    .W(32)
  ) u_timer (
    .clk_i    (clk_i),
    .reset_n_i(reset_n_i),
    .load_i   (load),
    .count_i  (load_cnt),
    .done_o   (done)
  );

  // Register writes, operation start and completion
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode               <= `MODE_READ;
      part_ms            <= `PART_CFG_RESET;
      page_addr          <= 32'h00000000;
      part_addr          <= 32'h00000000;
      word_addr          <= 32'h00000000;
      acc_cyc            <= 32'h00000000;
      acc_page           <= 32'h00000000;
      erased_cnt         <= 16'h0000;
      op                 <= `OP_IDLE;
      load               <= 1'b0;
      load_cnt           <= 32'h00000000;
      flash_erase_page_o <= 1'b0;
      flash_erase_all_o  <= 1'b0;
      flash_erase_ucfg_o <= 1'b0;
      flash_write_o      <= 1'b0;
      flash_addr_o       <= 32'h00000000;
      flash_wdata_o      <= 32'h00000000;
    end else begin
      load <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          `OFS_CONFIG: begin
            if (!busy) begin
              mode <= wdata_i[1:0];
            end
          end
          `OFS_PART_CFG: begin
            part_ms <= wdata_i[6:0];
          end
          `OFS_WORD_ADDR: begin
            word_addr <= {wdata_i[31:2], 2'h0};
          end
          `OFS_PAGE_ERASE, `OFS_PAGE_ALIAS_B: begin
            page_addr <= wdata_i;
            if (erase_ok) begin
              op                 <= `OP_PAGE;
              flash_erase_page_o <= 1'b1;
              flash_addr_o       <= wdata_i;
              load               <= 1'b1;
              load_cnt           <= PAGE_CYC;
            end
          end
          `OFS_FULL_ERASE: begin
            if (erase_ok && wdata_i[0]) begin
              op                <= `OP_ALL;
              flash_erase_all_o <= 1'b1;
              load              <= 1'b1;
              load_cnt          <= ALL_CYC;
            end
          end
          `OFS_UCFG_ERASE: begin
            if (erase_ok && wdata_i[0]) begin
              op                 <= `OP_UCFG;
              flash_erase_ucfg_o <= 1'b1;
              load               <= 1'b1;
              load_cnt           <= PAGE_CYC;
            end
          end
          `OFS_PART_ADDR: begin
            part_addr <= wdata_i;
            if (erase_ok) begin
              op                 <= `OP_PART;
              flash_erase_page_o <= 1'b1;
              flash_addr_o       <= wdata_i;
              load               <= 1'b1;
              load_cnt           <= part_cyc;
              if (wdata_i != acc_page) begin
                acc_page <= wdata_i;
                acc_cyc  <= 32'h00000000;
              end
            end
          end
          `OFS_WORD_DATA: begin
            // Software keeps each word to two writes per erase
            if ((mode == `MODE_WRITE) && !busy) begin
              op            <= `OP_WORD;
              flash_write_o <= 1'b1;
              flash_addr_o  <= word_addr;
              flash_wdata_o <= wdata_i;
              load          <= 1'b1;
              load_cnt      <= WRITE_CYC;
            end
          end
          default: begin
          end
        endcase
      end
      // Completion ends the operation and releases the array
      if (done) begin
        op                 <= `OP_IDLE;
        flash_erase_page_o <= 1'b0;
        flash_erase_all_o  <= 1'b0;
        flash_erase_ucfg_o <= 1'b0;
        flash_write_o      <= 1'b0;
        if (op == `OP_PART) begin
          if (acc_cyc + part_cyc >= PAGE_CYC) begin
            acc_cyc    <= 32'h00000000;
            erased_cnt <= erased_cnt + 16'h0001;
          end else begin
            acc_cyc <= acc_cyc + part_cyc;
          end
        end
      end
    end
  end

  // Ready flag follows the operation state
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_o <= 1'b1;
    end else begin
      ready_o <= !busy && !load;
    end
  end

  // Read data, registered one cycle after the strobe
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `OFS_READY:        rdata_o <= {31'h00000000, !busy};
        `OFS_CONFIG:       rdata_o <= {30'h00000000, mode};
        `OFS_PAGE_ERASE:   rdata_o <= page_addr;
        `OFS_PAGE_ALIAS_B: rdata_o <= page_addr;
        `OFS_PART_ADDR:    rdata_o <= part_addr;
        `OFS_PART_CFG:     rdata_o <= {25'h0, part_ms};
        `OFS_WORD_ADDR:    rdata_o <= word_addr;
        `OFS_WORD_DATA:    rdata_o <= {16'h0000, erased_cnt};
        default:           rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule // nvm_erase_controller

//--- verilog/nvm_erase_defs.vh
// Register map, field layout, mode codes and timing constants of the erase controller
`ifndef NVM_ERASE_DEFS_VH
`define NVM_ERASE_DEFS_VH
`define OFS_READY          12'h400
`define OFS_CONFIG         12'h504
`define OFS_PAGE_ERASE     12'h508
`define OFS_FULL_ERASE     12'h50C
`define OFS_PAGE_ALIAS_B   12'h510
`define OFS_UCFG_ERASE     12'h514
`define OFS_PART_ADDR      12'h518
`define OFS_PART_CFG       12'h51C
`define OFS_WORD_ADDR      12'h600
`define OFS_WORD_DATA      12'h604
`define PART_CFG_RESET     7'h0A
`define MODE_READ          2'h0
`define MODE_WRITE         2'h1
`define MODE_ERASE         2'h2
`define CLK_HZ             25000000
`define T_WRITE_US         41
`define T_PAGE_MS          85
`define T_ALL_MS           169
`define ACC_NUM            105
`define ACC_DEN            100
`define OP_IDLE            3'h0
`define OP_PAGE            3'h1
`define OP_ALL             3'h2
`define OP_UCFG            3'h3
`define OP_PART            3'h4
`define OP_WORD            3'h5
`endif

//--- verilog/nvm_tick_timer.v
// Cycle down-counter that reports completion of a timed flash operation
`timescale 1ns/10ps
module nvm_tick_timer #(
  parameter W = 32                 // Counter width
) (
  input  wire         clk_i,       // System clock
  input  wire         reset_n_i,   // Async reset, active low
  input  wire         load_i,      // Load a new count
  input  wire [W-1:0] count_i,     // Cycles to run
  output reg          done_o       // One-cycle pulse at expiry
);
  reg [W-1:0] remain;              // Cycles left
  reg         run;                 // Counting

  // Count down and pulse done on the last cycle
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain <= {W{1'b0}};
      run    <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        remain <= count_i;
        run    <= 1'b1;
      end else if (run) begin
        if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
          run    <= 1'b0;
          done_o <= 1'b1;
        end else begin
          remain <= remain - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // nvm_tick_timer
